// *** core/csts_pkg.sv ***
// Constants and types for the capture sync/trigger source selector
package csts_pkg;
   // Register byte offsets
   localparam logic [11:0] CSTS_OFS_CTRL = 12'h000;
   localparam logic [11:0] CSTS_OFS_IRQ_STAT = 12'h004;
   localparam logic [11:0] CSTS_OFS_IRQ_MASK = 12'h008;
   localparam logic [11:0] CSTS_OFS_STATE = 12'h00c;
   // Control register fields
   localparam int CSTS_SEL_LSB = 0;
   localparam int CSTS_SEL_W = 5;
   localparam int CSTS_FLAG_BIT = 6;
   localparam int CSTS_CASC_BIT = 8;
   // Interrupt bits
   localparam int CSTS_IRQ_W = 2;
   localparam int CSTS_IRQ_TRIG = 0;
   localparam int CSTS_IRQ_SELF = 1;
   localparam logic [1:0] CSTS_IRQ_RST = 2'h0;
   // State register bits
   localparam int CSTS_ST_CASC = 0;
   localparam int CSTS_ST_SELF = 1;
   localparam int CSTS_ST_NONE = 2;
   // Source select codes
   localparam logic [4:0] CSTS_SEL_NONE_LO = 5'h00;
   localparam logic [4:0] CSTS_SEL_OC_BASE = 5'h01;
   localparam logic [4:0] CSTS_SEL_OC_TOP = 5'h04;
   localparam logic [4:0] CSTS_SEL_TRIG_GEN = 5'h0a;
   localparam logic [4:0] CSTS_SEL_TMR_BASE = 5'h0b;
   localparam logic [4:0] CSTS_SEL_TMR_TOP = 5'h0f;
   localparam logic [4:0] CSTS_SEL_CAP_BASE = 5'h10;
   localparam logic [4:0] CSTS_SEL_CAP_TOP = 5'h13;
   localparam logic [4:0] CSTS_SEL_CMP_BASE = 5'h18;
   localparam logic [4:0] CSTS_SEL_CMP_TOP = 5'h1a;
   localparam logic [4:0] CSTS_SEL_CONV = 5'h1b;
   localparam logic [4:0] CSTS_SEL_CHARGE_TIME_MEASUREMENT_UNIT = 5'h1c;
   localparam logic [4:0] CSTS_SEL_NONE_HI = 5'h1f;
   localparam logic [4:0] CSTS_SEL_RESET = 5'h0d;
   // Trigger generator outputs 8..11 sit at vector index 0..3
   localparam int CSTS_TG_FIRST_OUT = 8;
   // Event sources from the surrounding peripherals
   typedef struct packed {
      logic [4:0] timer;
      logic [3:0] capture_channel;
      logic [3:0] compare_output_channel;
      logic [2:0] analog_comparator;
      logic first_converter;
      logic charge_time_measurement_unit;
      logic [3:0] trigger_generator_output;
   } csts_src_s;
endpackage

// *** core/csts_top.sv ***
// Sync/trigger source selector for one capture channel, APB slave
//
// Contract
// [RQ1] Five-bit select field at bits 4-0; codes 11111 and 00000 connect nothing
// [RQ2] Code 11100 routes the charge-time measurement unit event
// [RQ3] Code 11011 routes first converter; 11010..11000 comparators three..one
// [RQ4] Codes 10011 down to 10000 route capture channels four down to one
// [RQ5] Codes 01111 down to 01011 route timers five down to one
// [RQ6] Select field resets to 01101, timer three
// [RQ7] Code 01010 routes this channel's dedicated trigger generator output
// [RQ8] Trigger generator outputs 8..11 feed channels one..four, one each
// [RQ9] Codes 00100 down to 00001 route compare output channels four..one
// [RQ10] Cascade active only when both channels of the pair enable it
// [RQ11] Hardware sets trigger status flag on the selected source event
// [RQ12] Software reads the flag and may set or clear it by writes
// [RQ13] Software must not select this channel as its own source
// [RQ14] Converter and comparator selections meant for trigger use only
// [RQ15] Reserved codes connect no source, like the no-source codes
`timescale 1ns/1ps
module csts_top
   import csts_pkg::*;
#(
   parameter logic [1:0] CHAN_IDX = 2'h0
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire csts_src_s src_events,
   input wire logic partner_cascade_32bit_enable,
   output logic sync_trigger_pulse,
   output logic trigger_status,
   output logic cascade_active,
   output logic [4:0] sync_trigger_source_select,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic [4:0] sel_ff;
   logic flag_ff;
   logic casc_en_ff;
   logic casc_act_ff;
   logic pulse_ff;
   logic [1:0] stat_ff;
   logic [1:0] mask_ff;
   logic irq_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Source routing
   function automatic logic route(input logic [4:0] code, input csts_src_s ev,
                                  input logic [1:0] idx);
      logic hit;
      hit = 1'b0;
      if (code >= CSTS_SEL_OC_BASE && code <= CSTS_SEL_OC_TOP) begin
         hit = ev.compare_output_channel[2'(code - CSTS_SEL_OC_BASE)]; // RQ9
      end else if (code == CSTS_SEL_TRIG_GEN) begin
         hit = ev.trigger_generator_output[idx]; // RQ7 RQ8
      end else if (code >= CSTS_SEL_TMR_BASE && code <= CSTS_SEL_TMR_TOP) begin
         hit = ev.timer[3'(code - CSTS_SEL_TMR_BASE)]; // RQ5
      end else if (code >= CSTS_SEL_CAP_BASE && code <= CSTS_SEL_CAP_TOP) begin
         // Own channel never feeds itself
         if (2'(code - CSTS_SEL_CAP_BASE) != idx) begin
            hit = ev.capture_channel[2'(code - CSTS_SEL_CAP_BASE)]; // RQ4 RQ13
         end
      end else if (code >= CSTS_SEL_CMP_BASE && code <= CSTS_SEL_CMP_TOP) begin
         hit = ev.analog_comparator[2'(code - CSTS_SEL_CMP_BASE)]; // RQ3 RQ14
      end else if (code == CSTS_SEL_CONV) begin
         hit = ev.first_converter; // RQ3 RQ14
      end else if (code == CSTS_SEL_CHARGE_TIME_MEASUREMENT_UNIT) begin
         hit = ev.charge_time_measurement_unit; // RQ2
      end
      // Codes 00000, 11111 and reserved codes fall through as no source
      return hit; // RQ1 RQ15
   endfunction

   function automatic logic src_is_known(input logic [4:0] code);
      return (code >= CSTS_SEL_OC_BASE && code <= CSTS_SEL_OC_TOP) ||
             (code >= CSTS_SEL_TRIG_GEN && code <= CSTS_SEL_CAP_TOP) ||
             (code >= CSTS_SEL_CMP_BASE && code <= CSTS_SEL_CHARGE_TIME_MEASUREMENT_UNIT);
   endfunction

   wire logic [4:0] self_code = 5'(CSTS_SEL_CAP_BASE + {3'h0, CHAN_IDX});
   wire logic src_evt = route(sel_ff, src_events, CHAN_IDX); // RQ1
   wire logic sel_is_self = (sel_ff == self_code);
   wire logic sel_is_none = ~src_is_known(sel_ff);

   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   wire logic setup = psel & ~penable;
   wire logic access = psel & penable & pready_ff;
   wire logic wr = access & pwrite;
   wire logic rd = access & ~pwrite;
   wire logic hit_ctrl = (paddr == CSTS_OFS_CTRL);
   wire logic hit_stat = (paddr == CSTS_OFS_IRQ_STAT);
   wire logic hit_mask = (paddr == CSTS_OFS_IRQ_MASK);
   wire logic hit_state = (paddr == CSTS_OFS_STATE);
   wire logic hit_any = hit_ctrl | hit_stat | hit_mask | hit_state;
   wire logic wr_ctrl = wr & hit_ctrl;
   wire logic wr_mask = wr & hit_mask;
   wire logic rd_stat = rd & hit_stat;

   wire logic [31:0] rd_ctrl = {23'h0, casc_en_ff, 1'b0, flag_ff, 1'b0, sel_ff};
   wire logic [31:0] rd_state = {29'h0, sel_is_none, sel_is_self, casc_act_ff};
   wire logic [31:0] rd_mux = hit_ctrl ? rd_ctrl :
                              hit_stat ? {30'h0, stat_ff} :
                              hit_mask ? {30'h0, mask_ff} :
                              hit_state ? rd_state : 32'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Next values
   wire logic [4:0] nxt_sel = wr_ctrl ? pwdata[CSTS_SEL_LSB +: CSTS_SEL_W] : sel_ff;
   // Hardware set wins over a software clear in the same cycle
   wire logic nxt_flag = src_evt | (wr_ctrl ? pwdata[CSTS_FLAG_BIT] : flag_ff); // RQ11 RQ12
   wire logic nxt_casc_en = wr_ctrl ? pwdata[CSTS_CASC_BIT] : casc_en_ff;
   wire logic self_wr = wr_ctrl &
                        (pwdata[CSTS_SEL_LSB +: CSTS_SEL_W] == self_code);
   wire logic [1:0] irq_set = {self_wr, src_evt};
   // Only bits already shown to software are cleared by the read
   wire logic [1:0] irq_clr = rd_stat ? prdata_ff[1:0] : 2'h0;
   wire logic [1:0] nxt_stat = (stat_ff & ~irq_clr) | irq_set;
   wire logic [1:0] nxt_mask = wr_mask ? pwdata[CSTS_IRQ_W-1:0] : mask_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sel_ff <= CSTS_SEL_RESET; // RQ6
         flag_ff <= 1'b0;
         casc_en_ff <= 1'b0;
         stat_ff <= CSTS_IRQ_RST;
         mask_ff <= CSTS_IRQ_RST;
      end else begin
         sel_ff <= nxt_sel; // RQ1
         flag_ff <= nxt_flag; // RQ11 RQ12
         casc_en_ff <= nxt_casc_en;
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pulse_ff <= 1'b0;
         casc_act_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         pulse_ff <= src_evt;
         casc_act_ff <= casc_en_ff & partner_cascade_32bit_enable; // RQ10
         irq_ff <= |(stat_ff & mask_ff);
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata_ff <= 32'h0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         prdata_ff <= setup ? rd_mux : prdata_ff;
         pready_ff <= setup;
         pslverr_ff <= setup & ~hit_any;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign sync_trigger_pulse = pulse_ff;
   assign trigger_status = flag_ff;
   assign cascade_active = casc_act_ff;
   assign sync_trigger_source_select = sel_ff;
   assign irq = irq_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   reset_sel_a: assert property ($rose(reset_n) |-> sel_ff == 5'h0d) // RQ6
      else $error("select not at timer three after reset");
   none_code_a: assert property ((sel_ff == 5'h00 || sel_ff == 5'h1f) |=> // RQ1
      !sync_trigger_pulse) else $error("no-source code produced a pulse");
   reserved_code_a: assert property ((sel_ff inside {5'h05, 5'h06, 5'h07, 5'h08, // RQ15
      5'h09, 5'h14, 5'h15, 5'h16, 5'h17, 5'h1d, 5'h1e}) |=> !sync_trigger_pulse)
      else $error("reserved code produced a pulse");
   charge_time_measurement_unit_route_a: assert property ((sel_ff == 5'h1c && // RQ2
      src_events.charge_time_measurement_unit) |=> sync_trigger_pulse && trigger_status)
      else $error("charge-time event not routed");
   conv_cmp_a: assert property ((sel_ff == 5'h1b && src_events.first_converter) || // RQ3
      (sel_ff == 5'h18 && src_events.analog_comparator[0]) |=> sync_trigger_pulse)
      else $error("converter or comparator event not routed");
   cap_route_a: assert property ((sel_ff == 5'h13 && src_events.capture_channel[3] && // RQ4
      CHAN_IDX != 2'h3) |=> sync_trigger_pulse) else $error("capture four not routed");
   timer_route_a: assert property ((sel_ff == 5'h0d) |=> // RQ5
      sync_trigger_pulse == $past(src_events.timer[2])) else $error("timer three misrouted");
   trig_gen_a: assert property ((sel_ff == 5'h0a) |=> // RQ7 RQ8
      sync_trigger_pulse == $past(src_events.trigger_generator_output[CHAN_IDX]))
      else $error("trigger generator output misrouted");
   oc_route_a: assert property ((sel_ff == 5'h01 && src_events.compare_output_channel[0]) // RQ9
      |=> sync_trigger_pulse) else $error("compare one not routed");
   cascade_pair_a: assert property (cascade_active == // RQ10
      $past(casc_en_ff && partner_cascade_32bit_enable)) else $error("cascade mismatch");
   flag_set_a: assert property (src_evt |=> trigger_status ##1 // RQ11
      (trigger_status || $past(wr_ctrl))) else $error("trigger flag not set");
   flag_write_a: assert property ((wr_ctrl && !src_evt) |=> // RQ12
      trigger_status == $past(pwdata[6])) else $error("flag write ignored");
   self_block_a: assert property ((sel_ff == self_code) |=> !sync_trigger_pulse) // RQ13
      else $error("channel triggered itself");
   irq_level_a: assert property (##1 irq == $past(|(stat_ff & mask_ff)))
      else $error("interrupt level wrong");

   ////////////////////////////////////////////////////////////////////////////
   // Bus checks
   pready_pulse_a: assert property (pready
      |=> !pready)
      else $error("ready held for more than one cycle");
   pready_setup_a: assert property (
      pready == $past(setup))
      else $error("ready not one cycle after setup");
   slverr_ready_a: assert property (pslverr
      |-> pready)
      else $error("error without ready");
   slverr_map_a: assert property (pready
      |-> pslverr == $past(!hit_any))
      else $error("error flag does not match address map");
   rdata_hold_a: assert property (!$past(setup)
      |-> $stable(prdata))
      else $error("read data moved outside setup");
   unmapped_zero_a: assert property (pslverr
      |-> prdata == 32'h0)
      else $error("unmapped read data not zero");
   stat_ro_a: assert property ((wr && hit_stat && !src_evt)
      |=> $stable(stat_ff))
      else $error("status register took a write");
   unmapped_wr_a: assert property ((wr && !hit_any)
      |=> $stable(sel_ff) && $stable(mask_ff))
      else $error("unmapped write changed a register");
   mask_write_a: assert property (wr_mask
      |=> mask_ff == $past(pwdata[1:0]))
      else $error("mask write lost");
   mask_hold_a: assert property (!wr_mask
      |=> $stable(mask_ff))
      else $error("mask changed without write");

   ////////////////////////////////////////////////////////////////////////////
   // Select, flag and interrupt checks
   sel_write_a: assert property (wr_ctrl // RQ1
      |=> sel_ff == $past(pwdata[4:0]))
      else $error("select write lost");
   sel_hold_a: assert property (!wr_ctrl // RQ1
      |=> $stable(sel_ff))
      else $error("select changed without write");
   casc_write_a: assert property (wr_ctrl // RQ10
      |=> casc_en_ff == $past(pwdata[8]))
      else $error("cascade enable write lost");
   casc_hold_a: assert property (!wr_ctrl // RQ10
      |=> $stable(casc_en_ff))
      else $error("cascade enable changed without write");
   flag_hold_a: assert property ((!wr_ctrl && !src_evt) // RQ12
      |=> $stable(trigger_status))
      else $error("flag moved without cause");
   flag_wins_a: assert property ((src_evt && wr_ctrl) // RQ11
      |=> trigger_status)
      else $error("write beat hardware set of flag");
   pulse_follow_a: assert property ( // RQ1
      ##1 sync_trigger_pulse == $past(src_evt))
      else $error("pulse does not follow source");
   rd_ctrl_a: assert property ((pready && !pwrite && $past(hit_ctrl)) // RQ12
      |-> prdata[6] == $past(flag_ff) && prdata[4:0] == $past(sel_ff))
      else $error("control read back wrong");
   stat_set_a: assert property (src_evt // RQ11
      |=> stat_ff[0])
      else $error("trigger status bit not set");
   self_stat_a: assert property (self_wr // RQ13
      |=> stat_ff[1])
      else $error("self-select status bit not set");
   stat_clear_a: assert property ((rd_stat && !src_evt && !self_wr)
      |=> (stat_ff & $past(prdata_ff[1:0])) == 2'h0)
      else $error("status read did not clear");
   stat_hold_a: assert property ((!rd_stat && !src_evt && !self_wr)
      |=> $stable(stat_ff))
      else $error("status changed without cause");
   irq_quiet_a: assert property (((stat_ff & mask_ff) == 2'h0)
      |=> !irq)
      else $error("interrupt without unmasked status");
   rd_state_a: assert property ((pready && !pwrite && $past(hit_state)) // RQ15
      |-> prdata[2:0] == $past({sel_is_none, sel_is_self, casc_act_ff}))
      else $error("state read back wrong");

   ////////////////////////////////////////////////////////////////////////////
   // Routing checks per code
   oc_two_a: assert property ((sel_ff == 5'h02 && src_events.compare_output_channel[1]) // RQ9
      |=> sync_trigger_pulse)
      else $error("compare two not routed");
   oc_four_a: assert property ((sel_ff == 5'h04 && src_events.compare_output_channel[3]) // RQ9
      |=> sync_trigger_pulse)
      else $error("compare four not routed");
   timer_one_a: assert property ((sel_ff == 5'h0b && src_events.timer[0]) // RQ5
      |=> sync_trigger_pulse)
      else $error("timer one not routed");
   timer_two_a: assert property ((sel_ff == 5'h0c && src_events.timer[1]) // RQ5
      |=> sync_trigger_pulse)
      else $error("timer two not routed");
   timer_five_a: assert property ((sel_ff == 5'h0f && src_events.timer[4]) // RQ5
      |=> sync_trigger_pulse)
      else $error("timer five not routed");
   cap_one_a: assert property ((sel_ff == 5'h10 && src_events.capture_channel[0] && // RQ4
      CHAN_IDX != 2'h0) |=> sync_trigger_pulse)
      else $error("capture one not routed");
   cap_two_a: assert property ((sel_ff == 5'h11 && src_events.capture_channel[1] && // RQ4
      CHAN_IDX != 2'h1) |=> sync_trigger_pulse)
      else $error("capture two not routed");
   cmp_two_a: assert property ((sel_ff == 5'h19 && src_events.analog_comparator[1]) // RQ3
      |=> sync_trigger_pulse)
      else $error("comparator two not routed");
   cmp_three_a: assert property ((sel_ff == 5'h1a && src_events.analog_comparator[2]) // RQ3
      |=> sync_trigger_pulse)
      else $error("comparator three not routed");
   none_state_a: assert property (sel_is_none // RQ15
      |-> !src_evt)
      else $error("no-source code routed an event");
   self_state_a: assert property (sel_is_self // RQ13
      |-> !src_evt)
      else $error("own channel routed to itself");
   casc_both_a: assert property (cascade_active // RQ10
      |-> $past(casc_en_ff) && $past(partner_cascade_32bit_enable))
      else $error("cascade active with one side off");

   charge_time_measurement_unit_trig_c: cover property (sel_ff == 5'h1c ##1 sync_trigger_pulse);
   flag_clear_c: cover property (trigger_status ##1 wr_ctrl ##1 !trigger_status);
   irq_rise_c: cover property ($rose(irq) ##[1:4] rd_stat ##2 !irq);
   cascade_c: cover property ($rose(cascade_active));
   self_sel_c: cover property (self_wr ##1 stat_ff[1]);

endmodule

// *** tb/csts_src_model.sv ***
// Event sources around the capture channel, one pulse per request
`timescale 1ns/1ps
module csts_src_model
   import csts_pkg::*;
#(
   parameter logic [1:0] CHAN_IDX = 2'h0
) (
   input wire logic core_clk,
   input wire logic fire,
   input wire logic [4:0] code,
   output csts_src_s src_events
);
   csts_src_s nxt_ev;
   always_comb begin
      nxt_ev = '0;
      case (code)
         5'h01, 5'h02, 5'h03, 5'h04: nxt_ev.compare_output_channel[code - 5'h01] = 1'b1;
         5'h0a: nxt_ev.trigger_generator_output[CHAN_IDX] = 1'b1;
         5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f: nxt_ev.timer[code - 5'h0b] = 1'b1;
         5'h10, 5'h11, 5'h12, 5'h13: nxt_ev.capture_channel[code - 5'h10] = 1'b1;
         5'h18, 5'h19, 5'h1a: nxt_ev.analog_comparator[code - 5'h18] = 1'b1;
         5'h1b: nxt_ev.first_converter = 1'b1;
         5'h1c: nxt_ev.charge_time_measurement_unit = 1'b1;
         default: nxt_ev = '1;
      endcase
   end
   // Idle low between events
   always_ff @(posedge core_clk) begin
      src_events <= fire ? nxt_ev : '0;
   end
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the sync/trigger source selector
`timescale 1ns/1ps
module tb
   import csts_pkg::*;
;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic fire = 1'b0;
   logic p_en = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [4:0] code = 5'h00;
   logic [31:0] prdata;
   logic pready, pslverr, pulse, tstat, casc, irq, er;
   logic [4:0] sel;
   logic [31:0] rd;
   csts_src_s src;
   int errors = 0;
   int samples_checked = 0;
   // Rows: bit 5 pulse expected, bits 4-0 select code
   logic [5:0] rows [26] = '{6'h21, 6'h22, 6'h23, 6'h24, 6'h2a, 6'h2b, 6'h2c, 6'h2d, 6'h2e,
      6'h2f, 6'h30, 6'h31, 6'h33, 6'h38, 6'h39, 6'h3a, 6'h3b, 6'h3c, 6'h00, 6'h1f, 6'h05,
      6'h09, 6'h14, 6'h17, 6'h1d, 6'h1e};

   csts_top #(.CHAN_IDX(2'h2)) i_dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .src_events(src),
      .partner_cascade_32bit_enable(p_en), .sync_trigger_pulse(pulse),
      .trigger_status(tstat), .cascade_active(casc), .sync_trigger_source_select(sel),
      .irq(irq));
   csts_src_model #(.CHAN_IDX(2'h2)) i_src (.core_clk(core_clk), .fire(fire), .code(code),
      .src_events(src));

   initial begin
      forever #4 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task give_verdict();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task fire_src(input logic [4:0] c);
      @(posedge core_clk);
      code <= c;
      fire <= 1'b1;
      @(posedge core_clk);
      fire <= 1'b0;
      @(posedge core_clk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge core_clk);
      errors++;
      give_verdict();
   end
   initial begin
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      #1;
      chk(sel, 5'h0d);
      apb(1'b1, CSTS_OFS_CTRL, 32'h0);
      for (int i = 0; i < 26; i++) begin
         apb(1'b1, CSTS_OFS_CTRL, {27'h0, rows[i][4:0]});
         fire_src(rows[i][4:0]);
         chk(sel, rows[i][4:0]);
         chk(pulse, rows[i][5]);
         chk(tstat, rows[i][5]);
      end
      // Flag written by software
      apb(1'b1, CSTS_OFS_CTRL, 32'h4d);
      apb(1'b0, CSTS_OFS_CTRL, 32'h0);
      chk(rd, 32'h4d);
      apb(1'b1, CSTS_OFS_CTRL, 32'h0d);
      apb(1'b0, CSTS_OFS_CTRL, 32'h0);
      chk(rd, 32'h0d);
      // Cascade pair
      apb(1'b1, CSTS_OFS_CTRL, 32'h10d);
      repeat (2) @(posedge core_clk);
      #1;
      chk(casc, 1'b0);
      @(posedge core_clk);
      p_en <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      chk(casc, 1'b1);
      apb(1'b1, CSTS_OFS_CTRL, 32'h00d);
      repeat (2) @(posedge core_clk);
      #1;
      chk(casc, 1'b0);
      // Interrupt raise, mask and clear
      apb(1'b0, CSTS_OFS_IRQ_STAT, 32'h0);
      fire_src(5'h0d);
      repeat (2) @(posedge core_clk);
      #1;
      chk(irq, 1'b0);
      apb(1'b1, CSTS_OFS_IRQ_MASK, 32'h1);
      repeat (2) @(posedge core_clk);
      #1;
      chk(irq, 1'b1);
      apb(1'b0, CSTS_OFS_IRQ_STAT, 32'h0);
      chk(rd, 32'h1);
      repeat (3) @(posedge core_clk);
      #1;
      chk(irq, 1'b0);
      // Unmapped address
      apb(1'b0, 12'h010, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      // Own channel as source, then no-source code
      apb(1'b1, CSTS_OFS_CTRL, 32'h12);
      fire_src(5'h12);
      chk(pulse, 1'b0);
      apb(1'b0, CSTS_OFS_STATE, 32'h0);
      chk(rd, 32'h2);
      apb(1'b0, CSTS_OFS_IRQ_STAT, 32'h0);
      chk(rd, 32'h2);
      apb(1'b1, CSTS_OFS_CTRL, 32'h1f);
      apb(1'b0, CSTS_OFS_STATE, 32'h0);
      chk(rd, 32'h4);
      give_verdict();
   end
endmodule
